// ===== inc/tcvc_pkg.sv
// Shared constants and types for the timer with coherent channel values.
// Assumes an 8-bit register port and a single bus clock.
package tcvc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TSC = 8'h00;
  localparam logic [7:0] ADDR_CNT_H = 8'h01;
  localparam logic [7:0] ADDR_CNT_L = 8'h02;
  localparam logic [7:0] ADDR_MOD_H = 8'h03;
  localparam logic [7:0] ADDR_MOD_L = 8'h04;
  localparam int ADDR_CH_BASE = 5;
  localparam int CH_STRIDE = 3;
  localparam int CH_SC_OFS = 0;
  localparam int CH_VH_OFS = 1;
  localparam int CH_VL_OFS = 2;

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int TSC_OVF_BIT = 7;
  localparam int TSC_OIE_BIT = 6;
  localparam int TSC_CAS_BIT = 5;
  localparam int TSC_CLK_LSB = 3;
  localparam int TSC_PS_LSB = 0;
  localparam int CSC_FLAG_BIT = 7;
  localparam logic [1:0] CLK_NONE = 2'b00;
  localparam logic [1:0] CLK_BUS = 2'b01;
  localparam logic [1:0] CLK_FIXED = 2'b10;
  localparam logic [1:0] CLK_EXT = 2'b11;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] CNT_FREE_TOP = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam int EXT_MIN_RATIO = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCVC_MODE_CAPTURE,
    TCVC_MODE_COMPARE,
    TCVC_MODE_EDGE_PWM,
    TCVC_MODE_CENTER_PWM
  } tcvc_mode_t;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic mode_b;
    logic mode_a;
    logic [1:0] edge_level;
    logic [1:0] spare;
  } tcvc_ch_ctl_t;

endpackage

// ===== rtl/tcvc_edge_sync.sv
// Two-stage synchronizer with rising edge pulse.
// Assumes the source toggles no faster than a quarter of clock_i.
module tcvc_edge_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Source level and edge pulse
  input wire logic async_i,
  output logic rise_o
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Only sync_reg reads the first stage
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // One cycle pulse per source rising edge
  assign rise_o = sync_reg & ~last_reg;

endmodule

// ===== rtl/tcvc_prescaler.sv
// Binary prescaler: passes one of every 2^shift input ticks.
// Assumes tick_i is a one-cycle enable on the bus clock.
module tcvc_prescaler #(
  parameter int PS_W = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Source tick and divide select
  input wire logic tick_i,
  input wire logic [PS_W-1:0] shift_i,
  output logic count_o
);

  localparam int DIV_W = (1 << PS_W) - 1;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] mask;

  // Low bits that must all be set before a count passes
  assign mask = DIV_W'((32'd1 << shift_i) - 32'd1);
  assign count_o = tick_i & ((div_reg & mask) == mask);

  // Free running tick counter
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      div_reg <= '0;
    end else if (tick_i) begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

endmodule

// ===== rtl/tcvc_timer.sv
// Timer counter with clock select, overflow flag and coherent channel values.
// Assumes a byte-wide register port with reads answered one cycle later,
// and capture pins and clock sources already in the clock_i domain or slow.
//
// The address map and the strobed register port were left to the implementer.
module tcvc_timer import tcvc_pkg::*; #(
  parameter int CHANNELS = 2,
  parameter int PS_W = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // System status and clock sources
  input wire logic debug_mode_i,
  input wire logic loop_engaged_i,
  input wire logic fixed_clk_i,
  input wire logic ext_clk_i,
  // Channel pins
  input wire logic [CHANNELS-1:0] capture_pin_i,
  // Timer outputs
  output logic overflow_irq_o,
  output logic [15:0] counter_o,
  output logic [CHANNELS-1:0] channel_flag_o
);

  // ----------------------------------------------------------------
  // Timer control state
  // ----------------------------------------------------------------
  logic overflow_flag_reg;
  logic overflow_flag_next;
  logic overflow_interrupt_enable_reg;
  logic center_aligned_select_reg;
  logic [1:0] clock_select_field_reg;
  logic [PS_W-1:0] prescale_reg;
  logic ovf_armed_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic dir_down_reg;
  logic dir_down_next;
  logic ovf_set;
  logic [15:0] mod_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rd_mux;
  logic [CHANNELS*8-1:0] ch_rdata;
  logic [CHANNELS-1:0] ch_flags;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire tsc_wr = wr_i & (addr_i == ADDR_TSC);
  wire tsc_rd = rd_i & (addr_i == ADDR_TSC);
  wire cnt_wr = wr_i & ((addr_i == ADDR_CNT_H) | (addr_i == ADDR_CNT_L));
  wire modh_wr = wr_i & (addr_i == ADDR_MOD_H);
  wire modl_wr = wr_i & (addr_i == ADDR_MOD_L);

  // ----------------------------------------------------------------
  // Clock sources and prescaler
  // ----------------------------------------------------------------
  logic fixed_rise;
  logic ext_rise;
  logic src_tick;
  logic cnt_tick;

  // Fixed source crosses in only when the loop is engaged
  tcvc_edge_sync u_fixed_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(fixed_clk_i),
    .rise_o(fixed_rise)
  );

  // External source always crosses in
  tcvc_edge_sync u_ext_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(ext_clk_i),
    .rise_o(ext_rise)
  );

  // Source select; none stops the counter but keeps its value
  wire fixed_tick = loop_engaged_i ? fixed_rise : 1'b1;
  assign src_tick = (clock_select_field_reg == CLK_BUS) ? 1'b1 :
                    (clock_select_field_reg == CLK_FIXED) ? fixed_tick :
                    (clock_select_field_reg == CLK_EXT) ? ext_rise : 1'b0;

  // Counter is frozen while debug mode is active
  tcvc_prescaler #(
    .PS_W(PS_W)
  ) u_prescaler (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(src_tick & ~debug_mode_i),
    .shift_i(prescale_reg),
    .count_o(cnt_tick)
  );

  // ----------------------------------------------------------------
  // Main counter
  // ----------------------------------------------------------------
  // Terminal count: modulus, or free running when modulus is zero
  wire [15:0] top = (mod_reg == WORD_ZERO) ? CNT_FREE_TOP : mod_reg;
  wire [15:0] top_m1 = top - CNT_ONE;
  // Counter stepping from terminal minus one up to terminal
  wire pwm_load = cnt_tick & (cnt_reg == top_m1) & ~dir_down_reg;

  // Next count, direction and overflow event
  always_comb begin
    cnt_next = cnt_reg;
    dir_down_next = dir_down_reg;
    ovf_set = 1'b0;
    if (cnt_wr) begin
      cnt_next = WORD_ZERO;
      dir_down_next = 1'b0;
    end else if (cnt_tick) begin
      if (!center_aligned_select_reg) begin
        dir_down_next = 1'b0;
        if (cnt_reg == top) begin
          cnt_next = WORD_ZERO;
          ovf_set = 1'b1;
        end else begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end else if (dir_down_reg) begin
        if (cnt_reg == WORD_ZERO) begin
          cnt_next = cnt_reg + CNT_ONE;
          dir_down_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end else if (cnt_reg == top) begin
        cnt_next = cnt_reg - CNT_ONE;
        dir_down_next = 1'b1;
        ovf_set = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_ONE;
      end
    end
  end

  // Overflow flag: read while set, then write zero; a new event wins
  wire ovf_clear = tsc_wr & ~wdata_i[TSC_OVF_BIT] & ovf_armed_reg;
  assign overflow_flag_next = ovf_set | (overflow_flag_reg & ~ovf_clear);

  // Counter and modulus storage
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_reg <= WORD_ZERO;
      dir_down_reg <= 1'b0;
      mod_reg <= WORD_ZERO;
    end else begin
      cnt_reg <= cnt_next;
      dir_down_reg <= dir_down_next;
      if (modh_wr) begin
        mod_reg[15:8] <= wdata_i;
      end
      if (modl_wr) begin
        mod_reg[7:0] <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer status and control
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      overflow_flag_reg <= 1'b0;
      ovf_armed_reg <= 1'b0;
      overflow_interrupt_enable_reg <= 1'b0;
      center_aligned_select_reg <= 1'b0;
      clock_select_field_reg <= CLK_NONE;
      prescale_reg <= '0;
    end else begin
      overflow_flag_reg <= overflow_flag_next;
      if (tsc_wr | ovf_set) begin
        ovf_armed_reg <= 1'b0; // A new event restarts the clear sequence
      end else if (tsc_rd & overflow_flag_reg) begin
        ovf_armed_reg <= 1'b1;
      end
      if (tsc_wr) begin
        overflow_interrupt_enable_reg <= wdata_i[TSC_OIE_BIT];
        center_aligned_select_reg <= wdata_i[TSC_CAS_BIT];
        clock_select_field_reg <= wdata_i[TSC_CLK_LSB +: 2];
        prescale_reg <= wdata_i[TSC_PS_LSB +: PS_W];
      end
    end
  end

  // Status byte as read by software
  logic [7:0] tsc_byte;
  always_comb begin
    tsc_byte = BYTE_ZERO;
    tsc_byte[TSC_OVF_BIT] = overflow_flag_reg;
    tsc_byte[TSC_OIE_BIT] = overflow_interrupt_enable_reg;
    tsc_byte[TSC_CAS_BIT] = center_aligned_select_reg;
    tsc_byte[TSC_CLK_LSB +: 2] = clock_select_field_reg;
    tsc_byte[TSC_PS_LSB +: PS_W] = prescale_reg;
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar n = 0; n < CHANNELS; n++) begin : g_ch
    localparam logic [7:0] SC_A = 8'(ADDR_CH_BASE + n * CH_STRIDE + CH_SC_OFS);
    localparam logic [7:0] VH_A = 8'(ADDR_CH_BASE + n * CH_STRIDE + CH_VH_OFS);
    localparam logic [7:0] VL_A = 8'(ADDR_CH_BASE + n * CH_STRIDE + CH_VL_OFS);

    tcvc_ch_ctl_t ctl_reg;
    tcvc_mode_t mode;
    logic [15:0] val_reg;
    logic [15:0] rbuf_reg;
    logic [15:0] wbuf_reg;
    logic rlatch_reg;
    logic rhalf_hi_reg;
    logic wr_hi_reg;
    logic wr_lo_reg;
    logic pend_reg;
    logic pin_d_reg;
    logic armed_reg;

    // Per channel decode
    wire sc_wr = wr_i & (addr_i == SC_A);
    wire sc_rd = rd_i & (addr_i == SC_A);
    wire vh_wr = wr_i & (addr_i == VH_A);
    wire vl_wr = wr_i & (addr_i == VL_A);
    wire vh_rd = rd_i & (addr_i == VH_A);
    wire vl_rd = rd_i & (addr_i == VL_A);

    // Effective mode; center select overrides every channel
    assign mode = center_aligned_select_reg ? TCVC_MODE_CENTER_PWM :
                  ctl_reg.mode_b ? TCVC_MODE_EDGE_PWM :
                  ctl_reg.mode_a ? TCVC_MODE_COMPARE : TCVC_MODE_CAPTURE;
    wire is_cap = (mode == TCVC_MODE_CAPTURE);

    // Capture and compare events
    wire pin_edge = (capture_pin_i[n] & ~pin_d_reg & ctl_reg.edge_level[0]) |
                    (~capture_pin_i[n] & pin_d_reg & ctl_reg.edge_level[1]);
    wire cap_evt = is_cap & pin_edge;
    wire cmp_evt = ~is_cap & cnt_tick & (cnt_reg == val_reg);

    // Read coherency is live only in capture mode outside debug
    wire coh_rd = is_cap & ~debug_mode_i & (vh_rd | vl_rd);
    wire use_buf = is_cap & ~debug_mode_i & rlatch_reg;
    wire other_half = rhalf_hi_reg ? vl_rd : vh_rd;
    wire [7:0] vh_byte = use_buf ? rbuf_reg[15:8] : val_reg[15:8];
    wire [7:0] vl_byte = use_buf ? rbuf_reg[7:0] : val_reg[7:0];

    // Write sequence: buffer bytes, complete when both are in
    wire buf_wr = ~is_cap & ~debug_mode_i & (vh_wr | vl_wr);
    wire dir_wr = ~is_cap & debug_mode_i;
    wire both = buf_wr & (wr_hi_reg | vh_wr) & (wr_lo_reg | vl_wr);
    wire [15:0] wbuf_new = {vh_wr ? wdata_i : wbuf_reg[15:8], vl_wr ? wdata_i : wbuf_reg[7:0]};
    wire load_now = both & (clock_select_field_reg == CLK_NONE);
    wire load_pt = (mode == TCVC_MODE_COMPARE) ? cnt_tick : pwm_load;
    wire load_pend = pend_reg & load_pt;
    wire flag_clr = sc_wr & ~wdata_i[CSC_FLAG_BIT] & armed_reg;

    // Channel value register
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        val_reg <= WORD_ZERO;
      end else if (cap_evt) begin
        val_reg <= cnt_reg;
      end else if (dir_wr & vh_wr) begin
        val_reg[15:8] <= wdata_i;
      end else if (dir_wr & vl_wr) begin
        val_reg[7:0] <= wdata_i;
      end else if (load_now) begin
        val_reg <= wbuf_new;
      end else if (load_pend) begin
        val_reg <= wbuf_reg;
      end
    end

    // Read latch: first read captures both bytes, other half releases
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        rbuf_reg <= WORD_ZERO;
        rlatch_reg <= 1'b0;
        rhalf_hi_reg <= 1'b0;
      end else if (sc_wr) begin
        rlatch_reg <= 1'b0;
      end else if (coh_rd & ~rlatch_reg) begin
        rbuf_reg <= val_reg;
        rlatch_reg <= 1'b1;
        rhalf_hi_reg <= vh_rd;
      end else if (coh_rd & other_half) begin
        rlatch_reg <= 1'b0;
      end
    end

    // Write buffer, byte flags and pending transfer
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        wbuf_reg <= WORD_ZERO;
        wr_hi_reg <= 1'b0;
        wr_lo_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else if (sc_wr) begin
        wr_hi_reg <= 1'b0;
        wr_lo_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else if (buf_wr) begin
        wbuf_reg <= wbuf_new;
        wr_hi_reg <= ~both & (wr_hi_reg | vh_wr);
        wr_lo_reg <= ~both & (wr_lo_reg | vl_wr);
        pend_reg <= (both & ~load_now) | (pend_reg & ~load_pend);
      end else if (load_pend) begin
        pend_reg <= 1'b0;
      end
    end

    // Channel control and flag; a new event wins over the clear
    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        ctl_reg <= '0;
        armed_reg <= 1'b0;
        pin_d_reg <= 1'b0;
      end else begin
        pin_d_reg <= capture_pin_i[n];
        ctl_reg.flag <= cap_evt | cmp_evt | (ctl_reg.flag & ~flag_clr);
        if (sc_wr | cap_evt | cmp_evt) begin
          armed_reg <= 1'b0; // A new event restarts the clear sequence
        end else if (sc_rd & ctl_reg.flag) begin
          armed_reg <= 1'b1;
        end
        if (sc_wr) begin
          ctl_reg.irq_en <= wdata_i[6];
          ctl_reg.mode_b <= wdata_i[5];
          ctl_reg.mode_a <= wdata_i[4];
          ctl_reg.edge_level <= wdata_i[3:2];
        end
      end
    end

    // Read data and flag out of this channel
    assign ch_rdata[n*8 +: 8] = sc_rd ? {ctl_reg[7:2], 2'b00} :
                                vh_rd ? vh_byte :
                                vl_rd ? vl_byte : BYTE_ZERO;
    assign ch_flags[n] = ctl_reg.flag;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Combine the fixed registers and the channel answers
  always_comb begin
    rd_mux = BYTE_ZERO;
    if (addr_i == ADDR_TSC) begin
      rd_mux = tsc_byte;
    end else if (addr_i == ADDR_CNT_H) begin
      rd_mux = cnt_reg[15:8];
    end else if (addr_i == ADDR_CNT_L) begin
      rd_mux = cnt_reg[7:0];
    end else if (addr_i == ADDR_MOD_H) begin
      rd_mux = mod_reg[15:8];
    end else if (addr_i == ADDR_MOD_L) begin
      rd_mux = mod_reg[7:0];
    end
    for (int i = 0; i < CHANNELS; i++) begin
      rd_mux = rd_mux | ch_rdata[i*8 +: 8];
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_reg <= BYTE_ZERO;
    end else begin
      rdata_reg <= rd_i ? rd_mux : BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_reg;
  assign overflow_irq_o = overflow_flag_reg & overflow_interrupt_enable_reg;
  assign counter_o = cnt_reg;
  assign channel_flag_o = ch_flags;

endmodule

// ===== sim/tcvc_timer_sva.sv
// Checker for counter, overflow request and reset state at the timer ports.
// Assumes it is bound to the timer top and sees register writes on its port.
module tcvc_timer_sva import tcvc_pkg::*; #(
  parameter int CHANNELS = 2,
  parameter int PS_W = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic [7:0] rdata_o,
  // Status
  input wire logic debug_mode_i,
  input wire logic overflow_irq_o,
  input wire logic [15:0] counter_o,
  input wire logic [CHANNELS-1:0] channel_flag_o
);
  // ----------------------------------------------------------------
  // Shadow of control fields
  // ----------------------------------------------------------------
  logic oie_reg;
  logic cas_reg;
  logic [1:0] clk_reg;
  logic [15:0] mod_reg;
  wire logic tsc_wr = wr_i && (addr_i == ADDR_TSC);
  wire logic cnt_wr = wr_i && (addr_i == ADDR_CNT_H || addr_i == ADDR_CNT_L);
  wire logic [15:0] top_val = (mod_reg == WORD_ZERO) ? CNT_FREE_TOP : mod_reg;

  // Track status/control writes
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      oie_reg <= 1'b0;
      cas_reg <= 1'b0;
      clk_reg <= CLK_NONE;
    end else if (tsc_wr) begin
      oie_reg <= wdata_i[TSC_OIE_BIT];
      cas_reg <= wdata_i[TSC_CAS_BIT];
      clk_reg <= wdata_i[TSC_CLK_LSB +: 2];
    end
  end

  // Track modulus writes
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mod_reg <= WORD_ZERO;
    end else if (wr_i && addr_i == ADDR_MOD_H) begin
      mod_reg[15:8] <= wdata_i;
    end else if (wr_i && addr_i == ADDR_MOD_L) begin
      mod_reg[7:0] <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_reset_clears_all: assert property (disable iff (1'b0) sys_rst_i |=> counter_o == WORD_ZERO &&
    channel_flag_o == '0 && !overflow_irq_o && rdata_o == BYTE_ZERO) else $error("reset state wrong");
  chk_none_freezes_count: assert property (clk_reg == CLK_NONE && !cnt_wr |=> $stable(counter_o))
    else $error("counter moved without clock");
  chk_debug_freezes_count: assert property (debug_mode_i && !cnt_wr |=> $stable(counter_o))
    else $error("counter moved in debug");
  chk_irq_needs_enable: assert property (!oie_reg |-> !overflow_irq_o)
    else $error("request without enable");
  chk_wrap_sets_flag: assert property ((!cas_reg && oie_reg && !cnt_wr && counter_o == top_val)
    ##1 (counter_o == WORD_ZERO) |-> overflow_irq_o) else $error("no overflow on wrap");
  chk_turn_sets_flag: assert property ((cas_reg && oie_reg && !cnt_wr && counter_o == top_val)
    ##1 (counter_o == top_val - CNT_ONE) |-> overflow_irq_o) else $error("no overflow on turn");
  chk_count_write_clears: assert property (cnt_wr |=> counter_o == WORD_ZERO)
    else $error("counter write did not clear");
  chk_up_only_count: assert property (!cas_reg && !cnt_wr |=> counter_o == $past(counter_o) ||
    counter_o == $past(counter_o) + CNT_ONE || counter_o == WORD_ZERO) else $error("counter not counting up");
endmodule

bind tcvc_timer tcvc_timer_sva #(.CHANNELS(CHANNELS), .PS_W(PS_W)) i_tcvc_timer_sva (.clock_i, .sys_rst_i,
  .addr_i, .wdata_i, .wr_i, .rdata_o, .debug_mode_i, .overflow_irq_o, .counter_o, .channel_flag_o);

// ===== sim/tcvc_timer_tb_top.sv
// Self-checking bench for the timer with coherent channel values.
// Assumes the bound checker and a byte register port answered next cycle.
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module tcvc_timer_tb_top import tcvc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic debug_mode_i = 1'b0;
  logic loop_engaged_i = 1'b0;
  logic fixed_clk_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic [1:0] capture_pin_i = 2'b00;
  logic [7:0] rdata_o;
  logic overflow_irq_o;
  logic [15:0] counter_o;
  logic [1:0] channel_flag_o;
  logic [15:0] c;
  int fail_count = 0;
  int check_count = 0;
  localparam logic [7:0] SC0 = 8'(ADDR_CH_BASE + CH_SC_OFS);
  localparam logic [7:0] VH0 = 8'(ADDR_CH_BASE + CH_VH_OFS);
  localparam logic [7:0] VL0 = 8'(ADDR_CH_BASE + CH_VL_OFS);
  localparam logic [7:0] SC1 = 8'(SC0 + CH_STRIDE);
  localparam logic [7:0] VH1 = 8'(VH0 + CH_STRIDE);
  localparam logic [7:0] VL1 = 8'(VL0 + CH_STRIDE);

  tcvc_timer #(.CHANNELS(2), .PS_W(3)) i_tcvc_timer (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .debug_mode_i, .loop_engaged_i, .fixed_clk_i, .ext_clk_i, .capture_pin_i, .overflow_irq_o,
    .counter_o, .channel_flag_o);

  // Bus clock, 5 ns period
  always #2.5 clock_i = ~clock_i;

  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    rd_i <= 1'b0;
    wr_i <= 1'b1;
    @(posedge clock_i);
  endtask
  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    `CHK($sformatf("rdata %h", a), e, rdata_o)
    @(posedge clock_i);
  endtask
  task automatic step(input logic fx);
    fixed_clk_i <= fx;
    ext_clk_i <= !fx; // Eighth of bus rate
    idle(4);
    fixed_clk_i <= 1'b0;
    ext_clk_i <= 1'b0;
    idle(4);
  endtask
  task automatic pulse(input int ch);
    capture_pin_i[ch] <= 1'b1;
    idle(3);
    capture_pin_i[ch] <= 1'b0;
    idle(3);
  endtask
  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog well beyond the free-running wrap
  initial begin
    repeat (90000) @(posedge clock_i);
    fail_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    rd(VH0, 8'h00);
    rd(VL1, 8'h00);
    rd(ADDR_TSC, 8'h00);
    wr(8'hF0, 8'h5A);
    rd(8'hF0, 8'h00);
    // Buffered writes with no clock, both byte orders
    wr(SC0, 8'h10);
    wr(VH0, 8'h12);
    rd(VH0, 8'h00);
    wr(VL0, 8'h34);
    rd(VH0, 8'h12);
    wr(SC1, 8'h20);
    wr(VL1, 8'h78);
    wr(VH1, 8'h56);
    rd(VL1, 8'h78);
    // Capture: writes ignored, control write unlatches
    wr(SC1, 8'h04);
    wr(VH1, 8'hAA);
    rd(VH1, 8'h56);
    pulse(1);
    `CHK("flags", 2'b10, channel_flag_o)
    wr(SC1, 8'h04);
    rd(VL1, 8'h00);
    // Read latch held across debug
    wr(SC0, 8'h04);
    rd(VL0, 8'h34);
    pulse(0);
    debug_mode_i <= 1'b1;
    rd(VH0, 8'h00);
    debug_mode_i <= 1'b0;
    rd(VH0, 8'h12);
    rd(VH0, 8'h00);
    // Debug writes direct, finished sequence overrides
    wr(SC0, 8'h10);
    wr(VH0, 8'hAB);
    debug_mode_i <= 1'b1;
    wr(VL0, 8'hCD);
    rd(VL0, 8'hCD);
    rd(VH0, 8'h00);
    debug_mode_i <= 1'b0;
    wr(VL0, 8'hEF);
    rd(VH0, 8'hAB);
    rd(VL0, 8'hEF);
    // External clock: compare load on next step; channel 0 loads off that pin's step
    wr(ADDR_TSC, 8'h18);
    wr(ADDR_CNT_H, 8'h00);
    wr(VH0, 8'h11);
    wr(VL0, 8'h22);
    rd(VL0, 8'hEF);
    step(1'b0);
    `CHK("counter", 16'h0001, counter_o)
    rd(VL0, 8'h22);
    // Edge PWM with modulus 4
    wr(ADDR_MOD_L, 8'h04);
    wr(ADDR_TSC, 8'h58);
    wr(ADDR_CNT_L, 8'h00);
    wr(SC1, 8'h20);
    wr(VH1, 8'h00);
    wr(VL1, 8'h03);
    repeat (3) step(1'b0);
    rd(VL1, 8'h00);
    step(1'b0);
    rd(VL1, 8'h03);
    step(1'b0);
    `CHK("irq", 1'b1, overflow_irq_o)
    rd(ADDR_TSC, 8'hD8);
    wr(ADDR_TSC, 8'h58);
    idle(1);
    `CHK("irq", 1'b0, overflow_irq_o)
    // Center mode turns down at modulus
    wr(ADDR_TSC, 8'h78);
    wr(ADDR_CNT_L, 8'h00);
    repeat (5) step(1'b0);
    `CHK("counter", 16'h0003, counter_o)
    `CHK("irq", 1'b1, overflow_irq_o)
    // No clock freezes; bus and direct fixed clock step every cycle
    wr(ADDR_TSC, 8'h00);
    wr(ADDR_MOD_L, 8'h00);
    step(1'b0);
    `CHK("counter", 16'h0003, counter_o)
    for (int i = 1; i < 3; i++) begin
      wr(ADDR_TSC, 8'(i << TSC_CLK_LSB));
      idle(2);
      c = counter_o;
      idle(10);
      `CHK("delta", 16'h000A, 16'(counter_o - c))
    end
    loop_engaged_i <= 1'b1;
    wr(ADDR_CNT_H, 8'h00);
    step(1'b1);
    `CHK("counter", 16'h0001, counter_o)
    // Free run wraps from FFFF
    loop_engaged_i <= 1'b0;
    wr(ADDR_TSC, 8'h48);
    rd(ADDR_TSC, 8'hC8);
    wr(ADDR_TSC, 8'h48);
    wr(ADDR_CNT_H, 8'h00);
    idle(65500);
    `CHK("irq", 1'b0, overflow_irq_o)
    idle(50);
    `CHK("irq", 1'b1, overflow_irq_o)
    end_sim();
  end
endmodule
